// *** logic/pie_top.sv ***
// Top: peripheral interrupt enable register with sticky flags and request
//
// Contract
// RULE1 - Enable register at 17h, RW, reset zero
// RULE2 - Bit 7 gates port B change interrupt
// RULE3 - Bit 6 gates timer three interrupt
// RULE4 - Bit 5 gates timer two interrupt
// RULE5 - Bit 4 gates timer one interrupt
// RULE6 - Bit 3 gates capture two interrupt
// RULE7 - Bit 2 gates capture one interrupt
// RULE8 - Bit 1 gates transmit empty interrupt
// RULE9 - Bit 0 gates receive full interrupt
// RULE10 - Request high when flag and enable set
`timescale 1ns/1ps
module pie_top
  import pie_pkg::*;
#(
  parameter int AW = 8
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic [AW-1:0] reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [7:0]         reg_rdata,
  input  wire logic          port_b_change_evt,
  input  wire logic          timer_three_evt,
  input  wire logic          timer_two_evt,
  input  wire logic          timer_one_evt,
  input  wire logic          capture_two_evt,
  input  wire logic          capture_one_evt,
  input  wire logic          transmit_empty_evt,
  input  wire logic          receive_full_evt,
  output logic               irq
);

  // Register state
  logic [7:0] enable_q;    // Software enables
  logic [7:0] enable_d;
  logic [7:0] flags_q;     // Sticky event flags
  logic [7:0] flags_d;
  logic [7:0] rdata_q;     // Read data, one cycle after strobe
  logic [7:0] rdata_d;
  logic       irq_q;       // Registered request
  logic       irq_d;

  // Decoded strobes
  wire        hit_enable;  // Access to enable register
  wire        hit_flags;   // Access to flag register
  wire        hit_ctrl;    // Access to request status
  wire        wr_enable;
  wire        wr_flags;
  wire [7:0]  evt_vec;     // Events packed at enable bit positions
  wire [7:0]  gated;       // Flags passing their enables
  wire        any_req;     // Combined request
  wire [7:0]  rd_mux;      // Selected read value

  // Address decode
  assign hit_enable = (reg_addr == AW'(PIE_ENABLE_OFS));
  assign hit_flags  = (reg_addr == AW'(PIE_FLAGS_OFS));
  assign hit_ctrl   = (reg_addr == AW'(PIE_CTRL_OFS));
  assign wr_enable  = reg_wr & hit_enable;
  assign wr_flags   = reg_wr & hit_flags;

  // Sources packed in the same layout as the enable register
  assign evt_vec[PIE_PORT_B_INPUTS_BIT] = port_b_change_evt;
  assign evt_vec[PIE_TMR3_BIT]  = timer_three_evt;
  assign evt_vec[PIE_TMR2_BIT]  = timer_two_evt;
  assign evt_vec[PIE_TMR1_BIT]  = timer_one_evt;
  assign evt_vec[PIE_CAP2_BIT]  = capture_two_evt;
  assign evt_vec[PIE_CAP1_BIT]  = capture_one_evt;
  assign evt_vec[PIE_TXE_BIT]   = transmit_empty_evt;
  assign evt_vec[PIE_RXF_BIT]   = receive_full_evt;

  // Enable register: full byte write, no side effects
  assign enable_d = wr_enable ? reg_wdata : enable_q; // RULE1

  // Flags: write one clears, a same-cycle event wins over the clear
  assign flags_d = (flags_q & ~(wr_flags ? reg_wdata : 8'h00)) | evt_vec;

  // Per-bit gating of every source by its enable bit
  pie_gate #(
    .N (8)
  ) u_gate (
    .flags   (flags_q),
    .enables (enable_q), // RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8 RULE9
    .gated   (gated),
    .any_req (any_req)
  );

  // Request follows any enabled pending flag
  assign irq_d = any_req; // RULE10

  // Read mux; unmapped addresses read zero
  assign rd_mux = hit_enable ? enable_q :            // RULE1
                  hit_flags  ? flags_q  :
                  hit_ctrl   ? {7'h00, irq_q} :
                               8'h00;
  assign rdata_d = reg_rd ? rd_mux : 8'h00;

  // State update
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enable_q <= PIE_ENABLE_RST; // RULE1
      flags_q  <= PIE_FLAGS_RST;
      rdata_q  <= 8'h00;
      irq_q    <= 1'b0;
    end else begin
      enable_q <= enable_d;
      flags_q  <= flags_d;
      rdata_q  <= rdata_d;
      irq_q    <= irq_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_q;
  assign irq       = irq_q;

endmodule

// *** logic/pie_pkg.sv ***
// Package: register map and field layout of the peripheral interrupt block
package pie_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] PIE_ENABLE_OFS  = 8'h17; // Enable register, bank 1
  localparam logic [7:0] PIE_FLAGS_OFS   = 8'h16; // Sticky flags, bank 1
  localparam logic [7:0] PIE_CTRL_OFS    = 8'h18; // Combined request status
  // Enable bit positions
  localparam int PIE_PORT_B_INPUTS_BIT  = 7; // Port B change
  localparam int PIE_TMR3_BIT   = 6; // Timer three
  localparam int PIE_TMR2_BIT   = 5; // Timer two
  localparam int PIE_TMR1_BIT   = 4; // Timer one
  localparam int PIE_CAP2_BIT   = 3; // Capture two
  localparam int PIE_CAP1_BIT   = 2; // Capture one
  localparam int PIE_TXE_BIT    = 1; // Transmit buffer empty
  localparam int PIE_RXF_BIT    = 0; // Receive buffer full
  // Reset values
  localparam logic [7:0] PIE_ENABLE_RST = 8'h00; // All sources blocked
  localparam logic [7:0] PIE_FLAGS_RST  = 8'h00; // No pending events
endpackage

// *** logic/pie_gate.sv ***
// Gate: per-source enable masking and the combined request
`timescale 1ns/1ps
module pie_gate #(
  parameter int N = 8
) (
  input  wire logic [N-1:0] flags,
  input  wire logic [N-1:0] enables,
  output logic [N-1:0]      gated,
  output logic              any_req
);
  // A source passes only where its enable is set
  assign gated   = flags & enables;
  // Any passed source raises the request
  assign any_req = |gated;
endmodule

// *** dv/pie_checker.sv ***
// Checker: register port and request timing
`timescale 1ns/1ps
module pie_checker (input wire logic clk, nrst, reg_wr, reg_rd, irq,
  timer_one_evt, input wire logic [7:0] reg_addr, reg_wdata, reg_rdata);
  logic [7:0] en_q; // Enable mirror
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk or negedge nrst)
    en_q <= !nrst ? 8'h00 : reg_wr && reg_addr == 8'h17 ? reg_wdata : en_q;
  property p_a; !$past(reg_rd) |-> !reg_rdata; endproperty
  a_a: assert property (p_a) else $error("idle");
  property p_b; reg_rd && reg_addr == 8'h17 |=> reg_rdata == $past(en_q);
  endproperty
  a_b: assert property (p_b) else $error("rdbk");
  property p_c; reg_rd && reg_addr == 8'h20 |=> !reg_rdata; endproperty
  a_c: assert property (p_c) else $error("unmap");
  property p_d; timer_one_evt && en_q[4] && !reg_wr ##1 !reg_wr |=> irq;
  endproperty
  a_d: assert property (p_d) else $error("gate");
  property p_e; !$past(en_q) |-> !irq; endproperty
  a_e: assert property (p_e) else $error("mask");
  property p_f; $fell(irq) |-> $past(reg_wr, 2); endproperty
  a_f: assert property (p_f) else $error("drop");
  property p_g; irq && !$past(reg_wr) |=> irq; endproperty
  a_g: assert property (p_g) else $error("hold");
  property p_h; reg_wr && reg_addr == 8'h17 && !reg_wdata |-> ##2 !irq;
  endproperty
  a_h: assert property (p_h) else $error("off");
  c_a: cover property (timer_one_evt ##2 irq);
  c_b: cover property (irq ##1 !irq);
  c_c: cover property (reg_rd ##1 reg_rdata);
endmodule
bind pie_top pie_checker u_chk (.clk, .nrst, .reg_wr, .reg_rd, .irq,
  .timer_one_evt, .reg_addr, .reg_wdata, .reg_rdata);

// *** dv/pie_src.sv ***
// Partner: peripheral event sources
`timescale 1ns/1ps
module pie_src (input wire logic clk, input wire logic [7:0] go,
  output logic [7:0] ev);
  always_ff @(posedge clk) ev <= go; // One pulse per event
endmodule

// *** dv/pie_top_tb.sv ***
// Testbench: enable register and request against a model
`timescale 1ns/1ps
`define CK(a,b) begin check_count++; if ((a)!==(b)) begin err_count++; \
$display("[ERR] %0t bad %h", $time, a); end end
module pie_top_tb;
  logic clk, nrst, reg_wr, reg_rd, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, go, ev;
  int err_count, check_count, en, fl, i, d;
  pie_top DUT (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .port_b_change_evt(ev[7]), .timer_three_evt(ev[6]),
    .timer_two_evt(ev[5]), .timer_one_evt(ev[4]), .capture_two_evt(ev[3]),
    .capture_one_evt(ev[2]), .transmit_empty_evt(ev[1]),
    .receive_full_evt(ev[0]));
  pie_src SRC (.clk, .go, .ev);
  task wr(input logic [7:0] a, v); reg_addr <= a; reg_wdata <= v;
    reg_wr <= 1; @(posedge clk) reg_wr <= 0; @(posedge clk); endtask
  task rd(input logic [7:0] a, v); reg_addr <= a; reg_rd <= 1;
    @(posedge clk) reg_rd <= 0;
    @(posedge clk) `CK(reg_rdata, v) endtask
  task close_out; $display("%0d checks %0d errors", check_count, err_count);
    if (!err_count && check_count) $display("Testbench passed");
    else $display("Testbench failed");
    $finish; endtask
  initial begin clk = 0; forever #5 clk = ~clk; end
  initial begin #50000; err_count++; close_out; end
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, go} = 0;
    d = $urandom(97); d = $urandom;
    repeat (3) @(posedge clk); nrst <= 1;
    rd(8'h17, 8'h00); wr(8'h17, d[7:0]); wr(8'h20, 8'hff);
    rd(8'h17, d[7:0]); rd(8'h20, 8'h00); $display("register done");
    for (i = 0; i < 16; i++) begin
      fl = 1 << i % 8; en = i < 8 ? fl : 255 ^ fl;
      wr(8'h17, en[7:0]); wr(8'h16, 8'hff);
      @(posedge clk) go <= fl[7:0]; @(posedge clk) go <= 0;
      repeat (3) @(posedge clk);
      `CK(irq, en[i%8])
      rd(8'h18, {7'h00, en[i%8]});
      rd(8'h16, fl[7:0]);
    end
    wr(8'h17, 8'h00); $display("gating done");
    close_out;
  end
endmodule
